// [logic/gso_output_logic.sv]
// Function
// - Outputs on only when all conditions hold
// - Outputs off on loss, low input, fault
// - Coded variant accepts any correct-type actuator
// - Individual variant: foreign actuator means fault
// - Individual variant re-teaches without limit
// - Unique variant accepts factory pair only
// - Input lows up to 900 us ignored
// - Feedback input automatic or start monitored
// - Monitored: start pulse after detection, inputs
// - Start pulse high 30 ms to 5 s
// - Diagnostic output on in green states, follows yellow in teach-in and boundary
// - Running: green steady, outputs high
// - Inputs low: slow green, outputs off
// - Awaiting start: rapid green, outputs off
// - Boundary: slow yellow, outputs hold
// - Teach-in: rapid yellow until power off
// - Fault: slow red, all outputs low
// - Slow flash on and off equal
// - Rapid flash on to off 1:4
// - Own test pulses up to 300 us
`timescale 1ns/1ps
`default_nettype none
module gso_output_logic
#(
  parameter int unsigned          FILTER_CYC     = gso_pkg::FILTER_CYC,
  parameter int unsigned          START_MIN_CYC  = gso_pkg::START_MIN_CYC,
  parameter int unsigned          START_MAX_CYC  = gso_pkg::START_MAX_CYC,
  parameter int unsigned          TEST_PULSE_CYC = gso_pkg::TEST_PULSE_CYC,
  parameter int unsigned          TEST_GAP_CYC   = gso_pkg::TEST_GAP_CYC,
  parameter int unsigned          TICK_CYC       = gso_pkg::TICK_CYC,
  // Factory pairing code; value is arbitrary
  parameter logic [gso_pkg::ID_W-1:0] PAIRED_ID  = 16'h5a3c
)
(
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  // Fixed configuration
  input  wire gso_pkg::gso_code_t          variantSel,
  input  wire gso_pkg::gso_fb_t            feedbackMode,
  // Actuator detection
  input  wire gso_pkg::gso_act_t           act,
  // Safety and feedback inputs
  input  wire logic [gso_pkg::CH_N-1:0]    safetyIn,
  input  wire logic                        contactorFeedbackIn,
  input  wire logic                        faultIn,
  // Teach request and code store
  input  wire logic                        teachReq,
  input  wire logic                        storedValid,
  input  wire logic [gso_pkg::ID_W-1:0]    storedId,
  output var  logic                        learnWrite,
  output var  logic [gso_pkg::ID_W-1:0]    learnId,
  // Safety outputs and indicators
  output var  logic [gso_pkg::CH_N-1:0]    safetyOutputPair,
  output var  gso_pkg::gso_ind_t           ind
);

  // ============================================================
  // Input filtering
  logic [gso_pkg::CH_N-1:0] inFilt;

  for (genvar ch = 0; ch < gso_pkg::CH_N; ch++)
  begin : g_filt
    gso_low_filter
    #(
      .LIMIT (FILTER_CYC)
    )
    u_filt
    (
      .clk     (clk),
      .arst_n  (arst_n),
      .rawIn   (safetyIn[ch]),
      .filtOut (inFilt[ch])
    );
  end

  logic inputsHigh;
  assign inputsHigh = &inFilt;

  // ============================================================
  // Actuator code check
  logic match;
  logic wrongAct;
  logic teachable;

  // Judge the actuator in range against the coding variant
  always_comb
  begin
    match    = 1'b0;
    wrongAct = 1'b0;
    unique case (variantSel)
      gso_pkg::CODE_TYPE:
        match = act.present & act.typeOk;
      gso_pkg::CODE_INDIVIDUAL:
      begin
        match    = act.present & act.typeOk & storedValid & (act.id == storedId);
        wrongAct = act.present & storedValid & ~match;
      end
      gso_pkg::CODE_UNIQUE:
      begin
        match    = act.present & act.typeOk & (act.id == PAIRED_ID);
        wrongAct = act.present & ~match;
      end
      default:
        match = 1'b0;
    endcase
  end

  // Learning is only for the individual variant
  assign teachable = (variantSel == gso_pkg::CODE_INDIVIDUAL) & act.present & act.typeOk;

  // ============================================================
  // Start pulse measurement
  gso_pkg::gso_state_t state_q;
  gso_pkg::gso_state_t state_d;
  logic                fbPrev_q;
  logic                armed_q;
  logic [31:0]         hiCnt_q;
  logic                startOk_q;
  logic                fbOk;
  logic                measure;

  // Only pulses that begin once the guard is set up count
  assign measure = (state_q == gso_pkg::ST_WAIT_START) | (state_q == gso_pkg::ST_RUN);

  // time the high phase of each pulse
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fbPrev_q  <= 1'b0;
      armed_q   <= 1'b0;
      hiCnt_q   <= 32'h0;
      startOk_q <= 1'b0;
    end
    else
    begin
      fbPrev_q <= contactorFeedbackIn;
      if (!measure)
      begin
        armed_q   <= 1'b0;
        hiCnt_q   <= 32'h0;
        startOk_q <= 1'b0;
      end
      else if (contactorFeedbackIn && !fbPrev_q && state_q == gso_pkg::ST_WAIT_START)
      begin
        armed_q <= 1'b1;
        hiCnt_q <= 32'h1;
      end
      else if (contactorFeedbackIn && armed_q)
      begin
        // Saturate just past the limit so long holds stay rejected
        if (hiCnt_q <= 32'(START_MAX_CYC))
          hiCnt_q <= hiCnt_q + 32'h1;
      end
      else if (!contactorFeedbackIn && fbPrev_q && armed_q)
      begin
        armed_q <= 1'b0;
        if (hiCnt_q >= 32'(START_MIN_CYC) && hiCnt_q <= 32'(START_MAX_CYC))
          startOk_q <= 1'b1;
      end
    end
  end

  assign fbOk = (feedbackMode == gso_pkg::FB_AUTO) ? contactorFeedbackIn : startOk_q;

  // ============================================================
  // Operating state
  logic hold;

  // Boundary position freezes the state so outputs keep their value
  assign hold = act.present & act.boundary;

  // Next state; fault and teach-in are checked first
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      gso_pkg::ST_IDLE, gso_pkg::ST_WAIT_IN, gso_pkg::ST_WAIT_START, gso_pkg::ST_RUN:
      begin
        if (faultIn || wrongAct)
          state_d = gso_pkg::ST_FAULT;
        else if (teachReq && teachable)
          state_d = gso_pkg::ST_TEACH;
        else if (hold)
          state_d = state_q;
        else if (!match)
          state_d = gso_pkg::ST_IDLE;
        else if (!inputsHigh)
          state_d = gso_pkg::ST_WAIT_IN;
        else if (fbOk)
          state_d = gso_pkg::ST_RUN;
        else
          state_d = gso_pkg::ST_WAIT_START;
      end
      gso_pkg::ST_TEACH:
        state_d = gso_pkg::ST_TEACH;
      // Leave fault once the cause is gone and the guard is open
      gso_pkg::ST_FAULT:
        if (!faultIn && !act.present)
          state_d = gso_pkg::ST_IDLE;
      default:
        state_d = gso_pkg::ST_FAULT;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      state_q <= gso_pkg::ST_IDLE;
    else
      state_q <= state_d;
  end

  // ============================================================
  // Code store write
  logic                     learnWrite_q;
  logic                     firstDone_q;
  logic [gso_pkg::ID_W-1:0] learnId_q;

  // One write per teach-in; a blank store takes the first actuator
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      learnWrite_q <= 1'b0;
      firstDone_q  <= 1'b0;
      learnId_q    <= '0;
    end
    else
    begin
      learnWrite_q <= 1'b0;
      if (state_q != gso_pkg::ST_TEACH && state_d == gso_pkg::ST_TEACH)
      begin
        learnWrite_q <= 1'b1;
        learnId_q    <= act.id;
      end
      else if (teachable && !storedValid && !firstDone_q)
      begin
        learnWrite_q <= 1'b1;
        learnId_q    <= act.id;
        firstDone_q  <= 1'b1;
      end
    end
  end

  assign learnWrite = learnWrite_q;
  assign learnId    = learnId_q;

  // ============================================================
  // Self test pulses
  logic [31:0]              testCnt_q;
  logic                     testSel_q;
  logic [gso_pkg::CH_N-1:0] testMask;
  logic [gso_pkg::CH_N-1:0] out_q;

  // brief off pulse, channels in turn
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      testCnt_q <= 32'h0;
      testSel_q <= 1'b0;
    end
    else if (testCnt_q >= 32'(TEST_GAP_CYC + TEST_PULSE_CYC - 1))
    begin
      testCnt_q <= 32'h0;
      testSel_q <= ~testSel_q;
    end
    else
    begin
      testCnt_q <= testCnt_q + 32'h1;
    end
  end

  // Pulse lives in the last part of each gap period
  assign testMask = (testCnt_q >= 32'(TEST_GAP_CYC)) ?
                    (testSel_q ? 2'h2 : 2'h1) : 2'h0;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      out_q <= '0;
    else if (state_d == gso_pkg::ST_RUN)
      out_q <= ~testMask;
    else
      out_q <= '0;
  end

  assign safetyOutputPair = out_q;

  // ============================================================
  // Flash time base
  logic [31:0] tickCnt_q;
  logic [3:0]  phase_q;
  logic        slowOn;
  logic        fastOn;

  // Tick enable and flash phase
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tickCnt_q <= 32'h0;
      phase_q   <= 4'h0;
    end
    else if (tickCnt_q >= 32'(TICK_CYC - 1))
    begin
      tickCnt_q <= 32'h0;
      phase_q   <= (phase_q == gso_pkg::PHASE_LAST) ? 4'h0 : phase_q + 4'h1;
    end
    else
    begin
      tickCnt_q <= tickCnt_q + 32'h1;
    end
  end

  assign slowOn = phase_q < gso_pkg::SLOW_ON_END;
  assign fastOn = (phase_q == gso_pkg::FAST_ON_A) | (phase_q == gso_pkg::FAST_ON_B);

  // ============================================================
  // Indicators and diagnostic output
  gso_pkg::gso_ind_t ind_d;
  gso_pkg::gso_ind_t ind_q;

  // Pattern per operating state
  always_comb
  begin
    ind_d = '0;
    unique case (state_q)
      gso_pkg::ST_IDLE:
        ind_d.yellow = 1'b1;
      gso_pkg::ST_RUN:
      begin
        ind_d.green = 1'b1;
        ind_d.diag  = 1'b1;
      end
      gso_pkg::ST_WAIT_IN:
      begin
        ind_d.green = slowOn;
        ind_d.diag  = 1'b1;
      end
      gso_pkg::ST_WAIT_START:
      begin
        ind_d.green = fastOn;
        ind_d.diag  = 1'b1;
      end
      gso_pkg::ST_TEACH:
      begin
        ind_d.yellow = fastOn;
        ind_d.diag   = fastOn;
      end
      gso_pkg::ST_FAULT:
        ind_d.red = slowOn;
      default:
        ind_d.red = slowOn;
    endcase
    if (hold && state_q != gso_pkg::ST_FAULT && state_q != gso_pkg::ST_TEACH)
    begin
      ind_d        = '0;
      ind_d.yellow = slowOn;
      ind_d.diag   = slowOn;
    end
  end

  // Registered so indicator pins never glitch
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ind_q <= '0;
    else
      ind_q <= ind_d;
  end

  assign ind = ind_q;

endmodule
`default_nettype wire

// [common/gso_pkg.sv]
// ============================================================
// Shared constants and types for the guard sensor output logic
package gso_pkg;

  // ============================================================
  // Clock and time base
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned CYC_PER_US    = CLK_MHZ;
  localparam int unsigned CYC_PER_MS    = CLK_MHZ * 1000;

  // Low pulses on the safety inputs up to this long are ignored
  localparam int unsigned FILTER_US     = 900;
  localparam int unsigned FILTER_CYC    = FILTER_US * CYC_PER_US;
  // Accepted high time of a start pulse
  localparam int unsigned START_MIN_MS  = 30;
  localparam int unsigned START_MAX_MS  = 5000;
  localparam int unsigned START_MIN_CYC = START_MIN_MS * CYC_PER_MS;
  localparam int unsigned START_MAX_CYC = START_MAX_MS * CYC_PER_MS;
  // Off-going self test pulse on the safety outputs and its spacing
  localparam int unsigned TEST_PULSE_US = 300;
  localparam int unsigned TEST_PULSE_CYC = TEST_PULSE_US * CYC_PER_US;
  localparam int unsigned TEST_GAP_MS   = 100;
  localparam int unsigned TEST_GAP_CYC  = TEST_GAP_MS * CYC_PER_MS;
  // Flash time base: one tick, ten ticks per flash cycle
  localparam int unsigned TICK_MS       = 100;
  localparam int unsigned TICK_CYC      = TICK_MS * CYC_PER_MS;
  localparam logic [3:0]  PHASE_LAST    = 4'h9;
  localparam logic [3:0]  SLOW_ON_END   = 4'h5;
  localparam logic [3:0]  FAST_ON_A     = 4'h0;
  localparam logic [3:0]  FAST_ON_B     = 4'h5;

  // Actuator code width
  localparam int unsigned ID_W          = 16;
  // Number of safety input and output channels
  localparam int unsigned CH_N          = 2;

  // ============================================================
  // Modes and states
  typedef enum logic [1:0]
  {
    CODE_TYPE       = 2'h0,
    CODE_INDIVIDUAL = 2'h1,
    CODE_UNIQUE     = 2'h2
  } gso_code_t;

  typedef enum logic
  {
    FB_AUTO      = 1'b0,
    FB_MONITORED = 1'b1
  } gso_fb_t;

  typedef enum logic [2:0]
  {
    ST_IDLE       = 3'h0,
    ST_WAIT_IN    = 3'h1,
    ST_WAIT_START = 3'h3,
    ST_RUN        = 3'h2,
    ST_TEACH      = 3'h6,
    ST_FAULT      = 3'h4
  } gso_state_t;

  // ============================================================
  // Carriers
  typedef struct packed
  {
    logic            present;
    logic            typeOk;
    logic            boundary;
    logic [ID_W-1:0] id;
  } gso_act_t;

  typedef struct packed
  {
    logic green;
    logic red;
    logic yellow;
    logic diag;
  } gso_ind_t;

endpackage

// [logic/gso_low_filter.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Low pulse filter: output drops only after a long low
module gso_low_filter
#(
  parameter int unsigned LIMIT = gso_pkg::FILTER_CYC
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Raw and filtered level
  input  wire logic rawIn,
  output var  logic filtOut
);

  logic [31:0] lowCnt_q;
  logic        out_q;

  // Count low cycles; a rise restores the output at once
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lowCnt_q <= 32'h0;
      out_q    <= 1'b0;
    end
    else if (rawIn)
    begin
      lowCnt_q <= 32'h0;
      out_q    <= 1'b1;
    end
    else if (lowCnt_q >= 32'(LIMIT))
    begin
      out_q <= 1'b0;
    end
    else
    begin
      lowCnt_q <= lowCnt_q + 32'h1;
    end
  end

  assign filtOut = out_q;

endmodule
`default_nettype wire

// [verif/gso_output_logic_props.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Port checker for the guard sensor output logic
module gso_output_props
#(
  parameter int unsigned FILTER_CYC     = 8,
  parameter int unsigned TEST_PULSE_CYC = 3
)
(
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  // Watched inputs
  input  wire gso_pkg::gso_code_t       variantSel,
  input  wire gso_pkg::gso_fb_t         feedbackMode,
  input  wire gso_pkg::gso_act_t        act,
  input  wire logic [gso_pkg::CH_N-1:0] safetyIn,
  input  wire logic                     contactorFeedbackIn,
  input  wire logic                     faultIn,
  // Watched outputs
  input  wire logic                     learnWrite,
  input  wire logic [gso_pkg::CH_N-1:0] safetyOutputPair,
  input  wire gso_pkg::gso_ind_t        ind
);
  logic [15:0] lowCnt_q;
  logic [15:0] pulseCnt_q;

  // Low input run length; boundary hold freezes state, so restart there
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      lowCnt_q <= '0;
    else if (safetyIn == 2'h3 || (act.present && act.boundary))
      lowCnt_q <= '0;
    else if (lowCnt_q != 16'hffff)
      lowCnt_q <= lowCnt_q + 16'h1;

  // Length of a single-channel gap on the outputs
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      pulseCnt_q <= '0;
    else
      pulseCnt_q <= (^safetyOutputPair) ? pulseCnt_q + 16'h1 : 16'h0;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Outputs switching on in monitored mode
  sequence s_outs_rise;
    feedbackMode == gso_pkg::FB_MONITORED && safetyOutputPair == '0 ##1 safetyOutputPair != '0;
  endsequence

  a_fault_outs_off: assert property (faultIn |=> safetyOutputPair == '0)
    else $error("outputs on after fault");
  a_absent_outs_off: assert property (!act.present |=> safetyOutputPair == '0)
    else $error("outputs on without actuator");
  a_low_input_off: assert property (lowCnt_q >= 16'(FILTER_CYC + 3) |-> safetyOutputPair == '0)
    else $error("outputs on after long input low");
  a_test_pulse_len: assert property (pulseCnt_q <= 16'(TEST_PULSE_CYC))
    else $error("test pulse too long");
  a_on_needs_cause: assert property (safetyOutputPair != '0 |-> $past(act.present && !faultIn))
    else $error("outputs on without cause");
  a_red_fault_view: assert property (ind.red |-> !ind.green && !ind.yellow && !ind.diag && safetyOutputPair == '0)
    else $error("fault display wrong");
  a_green_view: assert property (ind.green |-> ind.diag && !ind.yellow && !ind.red)
    else $error("green display wrong");
  a_start_after_fall: assert property (s_outs_rise |-> !$past(contactorFeedbackIn))
    else $error("monitored start without falling edge");
  a_learn_pulse: assert property (learnWrite |-> variantSel == gso_pkg::CODE_INDIVIDUAL ##1 !learnWrite)
    else $error("learn write wrong");
endmodule
`default_nettype wire

// [verif/gso_downstream_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Downstream safety relay model
module gso_downstream_ctrl
#(
  parameter int unsigned TOL_CYC = 3
)
(
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  // Sensor safety outputs
  input  wire logic [gso_pkg::CH_N-1:0] safetyOutputPair,
  // Relay state and tolerance breach
  output var  logic                     relayOn,
  output var  logic                     tolErr
);
  int unsigned gapCnt_q;

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      gapCnt_q <= 0;
    else
      gapCnt_q <= (^safetyOutputPair) ? gapCnt_q + 1 : 0;

  // short gaps keep the relay in
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      relayOn <= 1'h0;
      tolErr  <= 1'h0;
    end
    else
    begin
      relayOn <= safetyOutputPair == 2'h3 || (relayOn && ^safetyOutputPair && gapCnt_q < TOL_CYC);
      tolErr  <= tolErr || gapCnt_q > TOL_CYC;
    end
endmodule
`default_nettype wire

// [verif/gso_output_logic_bench.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Bench for the guard sensor output logic
module gso_output_logic_bench;
  localparam logic [15:0] PAIR_ID = 16'h1b2d; // Arbitrary pairing code
  // Shortened counts keep the run within budget
  localparam int unsigned FILT_N  = 8;
  localparam int unsigned SMIN_N  = 20;
  localparam int unsigned SMAX_N  = 200;
  localparam int unsigned PULSE_N = 3;
  localparam int unsigned GAP_N   = 50;
  localparam int unsigned TICK_N  = 4;
  logic               clk          = 1'h0;
  logic               arst_n       = 1'h0;
  gso_pkg::gso_code_t variantSel   = gso_pkg::CODE_TYPE;
  gso_pkg::gso_fb_t   feedbackMode = gso_pkg::FB_AUTO;
  gso_pkg::gso_act_t  act          = '0;
  logic [1:0]         safetyIn     = 2'h3; // first in chain, inputs high
  logic               cfb          = 1'h0;
  logic               faultIn      = 1'h0;
  logic               teachReq     = 1'h0;
  logic               storedValid  = 1'h0;
  logic [15:0]        storedId     = 16'h0;
  logic               learnWrite;
  logic [15:0]        learnId;
  logic [1:0]         outs;
  gso_pkg::gso_ind_t  ind;
  logic               relayOn;
  logic               tolErr;
  int                 mismatches   = 0;
  int                 comparisons  = 0;
  int                 k;
  int                 j;
  logic [15:0]        sid;
  int                 w[3]         = '{12, 230, 25};

  // Clock
  initial
    forever #5 clk = ~clk;

  // Design with shortened counts
  gso_output_logic #(.FILTER_CYC(FILT_N), .START_MIN_CYC(SMIN_N), .START_MAX_CYC(SMAX_N),
    .TEST_PULSE_CYC(PULSE_N), .TEST_GAP_CYC(GAP_N), .TICK_CYC(TICK_N), .PAIRED_ID(PAIR_ID))
    u_dut (.clk(clk), .arst_n(arst_n),
    .variantSel(variantSel), .feedbackMode(feedbackMode), .act(act), .safetyIn(safetyIn),
    .contactorFeedbackIn(cfb), .faultIn(faultIn), .teachReq(teachReq), .storedValid(storedValid),
    .storedId(storedId), .learnWrite(learnWrite), .learnId(learnId), .safetyOutputPair(outs), .ind(ind));

  // Far side relay; it tolerates exactly one test pulse length
  gso_downstream_ctrl #(.TOL_CYC(PULSE_N)) u_relay (.clk(clk), .arst_n(arst_n), .safetyOutputPair(outs),
    .relayOn(relayOn), .tolErr(tolErr));

  // ============================================================
  // Helpers
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Settle after the edge before sampling
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic drive(input logic p, input logic t, input logic b, input logic [15:0] id, input logic [1:0] s);
    @(posedge clk);
    act      <= '{p, t, b, id};
    safetyIn <= s;
  endtask

  task automatic doReset(input gso_pkg::gso_code_t c, input gso_pkg::gso_fb_t f);
    @(posedge clk);
    arst_n       <= 1'h0;
    variantSel   <= c;
    feedbackMode <= f;
    act          <= '0;
    teachReq     <= 1'h0;
    cfb          <= (f == gso_pkg::FB_AUTO); // automatic feedback held high
    step(16);
    @(posedge clk);
    arst_n <= 1'h1;
  endtask

  // Bounded waits; running out ends the run
  task automatic waitOuts(input logic [1:0] e);
    int i;
    for (i = 0; i < 60 && outs !== e; i++) step(1);
    check("outs", outs, e);
    // A spent limit fails even if the value arrives late
    if (i == 60)
    begin
      mismatches++;
      final_report();
    end
  endtask

  task automatic waitInd(input int b);
    int i;
    for (i = 0; i < 60 && ind[b] !== 1'h1; i++) step(1);
    check("ind", ind[b], 1);
    if (i == 60)
    begin
      mismatches++;
      final_report();
    end
  endtask

  // On cycles of one indicator over a full ten-tick flash period
  task automatic countOn(input int b, input int e);
    int n;
    n = 0;
    repeat (40)
    begin
      step(1);
      n += ind[b];
    end
    check("flash", n, e);
  endtask

  // Expected pair for steady inputs
  function automatic logic [1:0] model(input logic idOk, input logic fbOk);
    return (act.present && act.typeOk && idOk && !faultIn && safetyIn == 2'h3 && fbOk) ? 2'h3 : 2'h0;
  endfunction

  // ============================================================
  // Main sequence
  initial
  begin
    void'($urandom(45890));
    doReset(gso_pkg::CODE_TYPE, gso_pkg::FB_AUTO);
    for (k = 0; k < 3; k++)
    begin
      drive(1'h1, 1'h1, 1'h0, 16'($urandom), 2'h3);
      step(1);
      waitOuts(model(1'h1, cfb));
    end
    step(4);
    check("ind", ind, 4'h9);
    check("relay", relayOn, 1);
    // Short dip ignored, long low drops the pair
    drive(1'h1, 1'h1, 1'h0, act.id, 2'h2);
    step(7);
    drive(1'h1, 1'h1, 1'h0, act.id, 2'h3);
    step(4);
    check("relay", relayOn, 1);
    drive(1'h1, 1'h1, 1'h0, act.id, 2'h1);
    waitOuts(2'h0);
    countOn(3, 20);
    // Fault entry and exit
    drive(1'h1, 1'h1, 1'h0, act.id, 2'h3);
    waitOuts(2'h3);
    @(posedge clk);
    faultIn <= 1'h1;
    waitOuts(2'h0);
    waitInd(2);
    countOn(2, 20);
    @(posedge clk);
    faultIn <= 1'h0;
    drive(1'h0, 1'h0, 1'h0, 16'h0, 2'h3);
    drive(1'h1, 1'h0, 1'h0, 16'($urandom), 2'h3);
    step(12);
    check("wrong type", {outs, ind.red}, 3'h0);
    // Monitored start: short, long, valid
    doReset(gso_pkg::CODE_TYPE, gso_pkg::FB_MONITORED);
    drive(1'h1, 1'h1, 1'h0, 16'($urandom), 2'h3);
    step(8);
    countOn(3, 8);
    for (k = 0; k < 3; k++)
    begin
      @(posedge clk);
      cfb <= 1'h1;
      step(w[k]);
      @(posedge clk);
      cfb <= 1'h0;
      step(6);
      check("start", |outs, k == 2);
    end
    // Boundary holds the pair while inputs fall
    drive(1'h1, 1'h1, 1'h1, act.id, 2'h0);
    step(20);
    check("hold", |outs, 1);
    countOn(1, 20);
    countOn(0, 20);
    drive(1'h1, 1'h1, 1'h0, act.id, 2'h0);
    waitOuts(2'h0);
    // Unique pair only
    doReset(gso_pkg::CODE_UNIQUE, gso_pkg::FB_AUTO);
    drive(1'h1, 1'h1, 1'h0, PAIR_ID, 2'h3);
    waitOuts(2'h3);
    @(posedge clk);
    teachReq <= 1'h1;
    drive(1'h1, 1'h1, 1'h0, PAIR_ID ^ 16'h0001, 2'h3);
    waitOuts(2'h0);
    waitInd(2);
    // Individual: foreign fault, run, teach, repeated
    for (k = 0; k < 2; k++)
    begin
      doReset(gso_pkg::CODE_INDIVIDUAL, gso_pkg::FB_AUTO);
      sid = 16'($urandom);
      // Blank store: first actuator is written, outputs stay off
      storedValid <= 1'h0;
      drive(1'h1, 1'h1, 1'h0, sid, 2'h3);
      step(1);
      check("blank learn", {learnWrite, learnId, outs}, {1'h1, sid, 2'h0});
      @(posedge clk);
      storedValid <= 1'h1;
      storedId    <= sid;
      drive(1'h1, 1'h1, 1'h0, sid ^ 16'h0008, 2'h3);
      waitInd(2);
      check("foreign", outs, 2'h0);
      drive(1'h0, 1'h0, 1'h0, 16'h0, 2'h3);
      step(4);
      drive(1'h1, 1'h1, 1'h0, sid, 2'h3);
      waitOuts(2'h3);
      @(posedge clk);
      teachReq <= 1'h1;
      for (j = 0; j < 20 && learnWrite !== 1'h1; j++) step(1);
      check("learn", {learnWrite, learnId}, {1'h1, sid});
      if (j == 20)
      begin
        mismatches++;
        final_report();
      end
      waitOuts(2'h0);
      countOn(1, 8);
    end
    check("tol", tolErr, 0);
    final_report();
  end
endmodule

// Checker beside the design top
bind gso_output_logic gso_output_props #(.FILTER_CYC(FILTER_CYC), .TEST_PULSE_CYC(TEST_PULSE_CYC)) u_props (
  .clk(clk), .arst_n(arst_n), .variantSel(variantSel), .feedbackMode(feedbackMode), .act(act),
  .safetyIn(safetyIn), .contactorFeedbackIn(contactorFeedbackIn), .faultIn(faultIn),
  .learnWrite(learnWrite), .safetyOutputPair(safetyOutputPair), .ind(ind));
`default_nettype wire
